/* src/i2crec_pkg.sv */
// Purpose: Shared constants and types for the I2C slave serial interface with bus recovery
// Assumes: 7-bit addressing only
// Notes:   Bit counts and default slave address live here
package i2crec_pkg;
  localparam int unsigned  I2CREC_ADDR_W     = 7;
  localparam logic [6:0]   I2CREC_ADDR_DEF   = 7'h60;
  localparam logic [3:0]   I2CREC_BITS_BYTE  = 4'h8;
  localparam logic [3:0]   I2CREC_ACK_SLOT   = 4'h8;
  localparam logic [3:0]   I2CREC_BIT_ZERO   = 4'h0;
  localparam logic [2:0]   I2CREC_MSB_IDX    = 3'h7;
  localparam logic [7:0]   I2CREC_BYTE_ZERO  = 8'h00;
  localparam logic         I2CREC_ACK_LEVEL  = 1'b0;

  typedef enum logic [2:0] {
    I2CREC_IDLE,
    I2CREC_ADDR,
    I2CREC_WDATA,
    I2CREC_RDATA,
    I2CREC_IGNORE
  } i2crec_state_t;

  // Byte handed from the link domain to the core domain
  typedef struct packed {
    logic       is_write;
    logic       first;
    logic [7:0] data;
  } i2crec_byte_t;
endpackage

/* src/i2crec_slave.sv */
// Purpose: I2C slave serial state machine that survives the software bus-recovery sequence
// Assumes: SCL from the master is the link clock; SDA is sampled into mclk for start/stop detection
// Notes:   Only the serial state resets on recovery; user-side data is untouched
`timescale 1ns/10ps

module i2crec_slave
  import i2crec_pkg::*;
#(
  parameter logic [I2CREC_ADDR_W-1:0] SLAVE_ADDR = I2CREC_ADDR_DEF
)
(
  // Core clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // I2C pins, output enables low while pulling low
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_b,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_b,
  // User side, core domain
  input  wire logic [7:0]  rd_data,
  output logic [7:0]       wr_data,
  output logic             wr_valid,
  output logic             wr_launch,
  output logic             busy
);

  // Pin synchronisers in the core domain: three stages, change taken when stages two and three agree
  logic [2:0] sda_sy_r, sda_sy_nxt;
  logic [2:0] scl_sy_r, scl_sy_nxt;
  logic       sda_f_r, sda_f_nxt;
  logic       scl_f_r, scl_f_nxt;

  always_comb
  begin
    sda_sy_nxt = {sda_sy_r[1:0], sda_i};
    scl_sy_nxt = {scl_sy_r[1:0], scl_i};
    sda_f_nxt  = (sda_sy_r[1] == sda_sy_r[2]) ? sda_sy_r[2] : sda_f_r;
    scl_f_nxt  = (scl_sy_r[1] == scl_sy_r[2]) ? scl_sy_r[2] : scl_f_r;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sda_sy_r <= 3'h7;
      scl_sy_r <= 3'h7;
      sda_f_r  <= 1'b1;
      scl_f_r  <= 1'b1;
    end
    else if (clk_en)
    begin
      sda_sy_r <= sda_sy_nxt;
      scl_sy_r <= scl_sy_nxt;
      sda_f_r  <= sda_f_nxt;
      scl_f_r  <= scl_f_nxt;
    end
  end

  logic start_det;
  logic stop_det;
  assign start_det = scl_f_r && scl_f_nxt && sda_f_r && !sda_f_nxt;
  assign stop_det  = scl_f_r && scl_f_nxt && !sda_f_r && sda_f_nxt;

  // Start and stop toggles, core domain; they only move while SCL stands high
  logic start_tg_r, start_tg_nxt, stop_tg_r, stop_tg_nxt;
  logic [7:0] rd_hold_r, rd_hold_nxt;
  always_comb
  begin
    start_tg_nxt = start_tg_r ^ start_det;
    stop_tg_nxt  = stop_tg_r ^ stop_det;
    rd_hold_nxt  = rd_data;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      start_tg_r <= 1'b0;
      stop_tg_r  <= 1'b0;
      rd_hold_r  <= I2CREC_BYTE_ZERO;
    end
    else if (clk_en)
    begin
      start_tg_r <= start_tg_nxt;
      stop_tg_r  <= stop_tg_nxt;
      rd_hold_r  <= rd_hold_nxt;
    end
  end

  // Link domain, clocked by SCL; rises latch data, falls change SDA drive
  logic          st_tg_seen_r, sp_tg_seen_r;
  i2crec_state_t st_r, st_nxt;
  logic [3:0]    bit_r, bit_nxt;
  logic [7:0]    sh_r, sh_nxt;
  logic          first_r, first_nxt;
  logic          byte_tg_r, byte_tg_nxt;
  i2crec_byte_t  byte_r, byte_nxt;
  logic          wr_cmd_r, wr_cmd_nxt;
  logic          start_pend, stop_pend;

  // Toggles stand still through the SCL low phase, so the next SCL edge takes them; an SCL-clocked pair lags two bits
  assign start_pend = (start_tg_r != st_tg_seen_r);
  assign stop_pend  = (stop_tg_r != sp_tg_seen_r);

  always_comb
  begin
    st_nxt      = st_r;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    first_nxt   = first_r;
    byte_tg_nxt = byte_tg_r;
    byte_nxt    = byte_r;
    wr_cmd_nxt  = wr_cmd_r;
    if (start_pend)
    begin
      st_nxt     = I2CREC_ADDR;
      bit_nxt    = 4'h1;
      sh_nxt     = {sh_r[6:0], sda_i};
      wr_cmd_nxt = 1'b0;
    end
    else if (stop_pend)
      st_nxt = I2CREC_IDLE;
    else
    begin
      case (st_r)
        I2CREC_ADDR, I2CREC_WDATA:
        begin
          if (bit_r == I2CREC_ACK_SLOT)
            bit_nxt = I2CREC_BIT_ZERO;
          else
          begin
            sh_nxt  = {sh_r[6:0], sda_i};
            bit_nxt = bit_r + 4'h1;
          end
          if (bit_r == I2CREC_BITS_BYTE - 4'h1 && st_r == I2CREC_ADDR)
          begin
            if (sh_r[6:0] == SLAVE_ADDR)
            begin
              first_nxt  = 1'b1;
              wr_cmd_nxt = !sda_i;
            end
            else
              st_nxt = I2CREC_IGNORE;
          end
          if (bit_r == I2CREC_BITS_BYTE - 4'h1 && st_r == I2CREC_WDATA)
          begin
            byte_nxt    = '{is_write: 1'b1, first: first_r, data: {sh_r[6:0], sda_i}};
            byte_tg_nxt = !byte_tg_r;
            first_nxt   = 1'b0;
          end
          if (bit_r == I2CREC_ACK_SLOT && st_r == I2CREC_ADDR)
            st_nxt = sh_r[0] ? I2CREC_RDATA : I2CREC_WDATA;
          if (bit_r == I2CREC_ACK_SLOT && st_r == I2CREC_ADDR && sh_r[0])
            sh_nxt = rd_hold_r;
        end
        I2CREC_RDATA:
        begin
          if (bit_r == I2CREC_ACK_SLOT)
          begin
            bit_nxt = I2CREC_BIT_ZERO;
            if (sda_i)
              st_nxt = I2CREC_IGNORE;
            else
              sh_nxt = rd_hold_r;
          end
          else
          begin
            sh_nxt  = {sh_r[6:0], 1'b1};
            bit_nxt = bit_r + 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge scl_i)
  begin
    if (!rst_b)
    begin
      st_r         <= I2CREC_IDLE;
      bit_r        <= I2CREC_BIT_ZERO;
      sh_r         <= I2CREC_BYTE_ZERO;
      first_r      <= 1'b0;
      byte_tg_r    <= 1'b0;
      byte_r       <= '0;
      wr_cmd_r     <= 1'b0;
      st_tg_seen_r <= 1'b0;
      sp_tg_seen_r <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      bit_r        <= bit_nxt;
      sh_r         <= sh_nxt;
      first_r      <= first_nxt;
      byte_tg_r    <= byte_tg_nxt;
      byte_r       <= byte_nxt;
      wr_cmd_r     <= wr_cmd_nxt;
      st_tg_seen_r <= start_tg_r;
      sp_tg_seen_r <= stop_tg_r;
    end
  end

  // SDA drive set on SCL fall so it is stable across the next high phase
  logic drv_low_r, drv_low_nxt;
  always_comb
  begin
    drv_low_nxt = 1'b0;
    if (start_pend || stop_pend)
      drv_low_nxt = 1'b0;
    else if (st_r == I2CREC_ADDR && bit_r == I2CREC_BITS_BYTE && sh_r[7:1] == SLAVE_ADDR)
      drv_low_nxt = (I2CREC_ACK_LEVEL == 1'b0);
    else if (st_r == I2CREC_WDATA && bit_r == I2CREC_BITS_BYTE)
      drv_low_nxt = 1'b1;
    else if (st_r == I2CREC_RDATA && bit_r != I2CREC_ACK_SLOT)
      drv_low_nxt = !sh_r[I2CREC_MSB_IDX];
  end
  always_ff @(negedge scl_i)
  begin
    if (!rst_b)
      drv_low_r <= 1'b0;
    else
      drv_low_r <= drv_low_nxt;
  end

  // Start or stop seen in the core domain cuts the drive at once, without waiting for SCL
  logic cut_r, cut_nxt;
  logic drv_sy1_r, drv_sy2_r;
  always_comb
  begin
    cut_nxt = cut_r;
    if (start_det || stop_det)
      cut_nxt = 1'b1;
    else if (!drv_sy2_r)
      cut_nxt = 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cut_r     <= 1'b0;
      drv_sy1_r <= 1'b0;
      drv_sy2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      cut_r     <= cut_nxt;
      drv_sy1_r <= drv_low_r;
      drv_sy2_r <= drv_sy1_r;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_b = !(drv_low_r && !cut_r);
  assign scl_o    = 1'b0;
  assign scl_oe_b = 1'b1;

  // Core side: bytes cross by toggle plus three stages, the write command as a level through two stages; stop may launch a write
  logic [2:0]   btg_r, btg_nxt;
  logic [1:0]   wcmd_sy_r, wcmd_sy_nxt;
  logic [7:0]   wr_data_r, wr_data_nxt;
  logic         wr_valid_r, wr_valid_nxt;
  logic         wr_launch_r, wr_launch_nxt;
  logic         wr_got_r, wr_got_nxt;
  logic         busy_r, busy_nxt;
  always_comb
  begin
    btg_nxt       = {btg_r[1:0], byte_tg_r};
    wcmd_sy_nxt   = {wcmd_sy_r[0], wr_cmd_r};
    wr_data_nxt   = wr_data_r;
    wr_valid_nxt  = (btg_r[2] != btg_r[1]);
    wr_got_nxt    = wr_got_r;
    wr_launch_nxt = 1'b0;
    busy_nxt      = busy_r;
    if (btg_r[2] != btg_r[1])
    begin
      wr_data_nxt = byte_r.data;
      wr_got_nxt  = 1'b1;
    end
    if (start_det)
    begin
      wr_got_nxt = 1'b0;
      busy_nxt   = 1'b1;
    end
    else if (stop_det)
    begin
      wr_launch_nxt = wr_got_r && wcmd_sy_r[1];
      wr_got_nxt    = 1'b0;
      busy_nxt      = 1'b0;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      btg_r       <= 3'h0;
      wcmd_sy_r   <= 2'h0;
      wr_data_r   <= I2CREC_BYTE_ZERO;
      wr_valid_r  <= 1'b0;
      wr_launch_r <= 1'b0;
      wr_got_r    <= 1'b0;
      busy_r      <= 1'b0;
    end
    else if (clk_en)
    begin
      btg_r       <= btg_nxt;
      wcmd_sy_r   <= wcmd_sy_nxt;
      wr_data_r   <= wr_data_nxt;
      wr_valid_r  <= wr_valid_nxt;
      wr_launch_r <= wr_launch_nxt;
      wr_got_r    <= wr_got_nxt;
      busy_r      <= busy_nxt;
    end
  end

  // User data is only reported; the serial reset never reaches it
  assign wr_data   = wr_data_r;
  assign wr_valid  = wr_valid_r;
  assign wr_launch = wr_launch_r;
  assign busy      = busy_r;

endmodule // i2crec_slave

/* tb/i2crec_slave_assertions.sv */
// Purpose: Checker for the I2C slave pins and user strobes
// Assumes: Bound to i2crec_slave, core clock domain
// Notes:   Bounds cover the start/stop filter latency
`timescale 1ns/10ps
module i2crec_slave_assertions
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Pins
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe_b,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_b,
  // User side
  input wire logic [7:0] wr_data,
  input wire logic       wr_valid,
  input wire logic       wr_launch,
  input wire logic       busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_start; scl_i && $fell(sda_i); endsequence
  sequence s_stop; scl_i && $rose(sda_i); endsequence
  property p_pins; !scl_o && !sda_o && scl_oe_b; endproperty
  a_pins: assert property (p_pins) else $error("pin driven high");
  property p_start_rel; s_start |-> ##[1:8] sda_oe_b; endproperty
  a_start_rel: assert property (p_start_rel) else $error("start kept sda");
  property p_start_busy; s_start |-> ##[1:8] busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start missed");
  property p_stop_idle; s_stop |-> ##[1:8] !busy; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
  property p_drive_busy; !sda_oe_b |-> busy; endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("drive when idle");
  property p_oe_edge; $fell(sda_oe_b) |-> !scl_i; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("drive at scl high");
  property p_wv; wr_valid |=> !wr_valid; endproperty
  a_wv: assert property (p_wv) else $error("wr_valid long");
  property p_wl; wr_launch |-> !busy ##1 !wr_launch; endproperty
  a_wl: assert property (p_wl) else $error("bad launch");
  property p_wdata; $changed(wr_data) |-> wr_valid; endproperty
  a_wdata: assert property (p_wdata) else $error("wr_data moved");
endmodule // i2crec_slave_assertions

bind i2crec_slave i2crec_slave_assertions i2crec_slave_assertions_i (.mclk(mclk), .rst_b(rst_b), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .wr_data(wr_data),
  .wr_valid(wr_valid), .wr_launch(wr_launch), .busy(busy));

/* tb/i2crec_master.sv */
// Purpose: Behavioural I2C master for the slave bench
// Assumes: Pull-ups on both lines; half bit is 80 ns
// Notes:   SCL stands high between frames
`timescale 1ns/10ps
module i2crec_master
(
  // Bus
  input wire logic sda,
  output logic     scl_low,
  output logic     sda_low
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Also a repeated start when entered with SCL low
  task automatic start;
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b1;
    #40;
  endtask
  task automatic stop;
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #40 scl_low = 1'b0;
    #40 s = sda;
    #40 scl_low = 1'b1;
    #40;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
  // Link flops need SCL edges while reset is low
  task automatic tog;
    #80 scl_low = 1'b1;
    #80 scl_low = 1'b0;
  endtask
endmodule // i2crec_master

/* tb/tb.sv */
// Purpose: Self-checking bench for the I2C slave with bus recovery
// Assumes: 125 MHz core clock, 160 ns SCL period
// Notes:   Reset is stretched so SCL can toggle inside it
`timescale 1ns/10ps
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, v); end end
module tb;
  import i2crec_pkg::*;
  localparam logic [6:0] ADR = I2CREC_ADDR_DEF;
  logic       mclk    = 1'b0;
  logic       rst_b   = 1'b0;
  logic [7:0] rd_data = 8'hff;
  logic       scl_low, sda_low, scl_oe_b, sda_oe_b, busy, wr_valid, wr_launch, ack;
  logic [7:0] wr_data, q;
  wire logic  scl = !(scl_low || !scl_oe_b);
  wire logic  sda = !(sda_low || !sda_oe_b);
  int         err_total = 0;
  int         n_checks  = 0;
  int         n_launch  = 0;
  int         n_valid   = 0;
  int         cyc       = 0;
  i2crec_slave i2crec_slave_i (.mclk(mclk), .rst_b(rst_b), .clk_en(1'b1), .scl_i(scl), .scl_o(), .scl_oe_b(scl_oe_b),
    .sda_i(sda), .sda_o(), .sda_oe_b(sda_oe_b), .rd_data(rd_data), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_launch(wr_launch), .busy(busy));
  i2crec_master i2crec_master_i (.sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (wr_launch) n_launch++;
    if (wr_valid) n_valid++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic addr(input logic rw, input logic [6:0] a, input logic exp_ack);
    i2crec_master_i.start();
    i2crec_master_i.xfer({a, rw}, 1'b1, q, ack);
    `CHK("ack", exp_ack, ack)
  endtask
  task automatic idle_chk;
    repeat (10) @(posedge mclk);
    #1 `CHK("busy", 1'b0, busy)
    `CHK("oe", 1'b1, sda_oe_b)
  endtask
  task automatic recover;
    i2crec_master_i.start();
    repeat (9) i2crec_master_i.bit_io(1'b1, ack);
    i2crec_master_i.start();
    i2crec_master_i.stop();
  endtask
  task automatic t_probe;
    addr(1'b1, ADR, 1'b0);
    i2crec_master_i.stop();
    idle_chk();
    addr(1'b1, ADR ^ 7'h01, 1'b1);
    i2crec_master_i.stop();
    idle_chk();
  endtask
  task automatic t_read;
    @(posedge mclk) #1 rd_data = 8'h5a;
    addr(1'b1, ADR, 1'b0);
    i2crec_master_i.xfer(8'hff, 1'b1, q, ack);
    `CHK("rd", 8'h5a, q)
    i2crec_master_i.stop();
    idle_chk();
  endtask
  // Slave holds SDA low mid-read, so the first start cannot be seen
  task automatic t_recover;
    @(posedge mclk) #1 rd_data = 8'h00;
    addr(1'b1, ADR, 1'b0);
    repeat (3) i2crec_master_i.bit_io(1'b1, ack);
    recover();
    idle_chk();
    @(posedge mclk) #1 rd_data = 8'hff;
    addr(1'b1, ADR, 1'b0);
    i2crec_master_i.stop();
  endtask
  task automatic t_write;
    n_launch = 0;
    addr(1'b0, ADR, 1'b0);
    n_valid = 0;
    i2crec_master_i.xfer(8'hc3, 1'b1, q, ack);
    `CHK("wack", 1'b0, ack)
    i2crec_master_i.stop();
    idle_chk();
    `CHK("wdata", 8'hc3, wr_data)
    `CHK("launch", 1, n_launch)
    `CHK("valid", 1, n_valid)
  endtask
  task automatic t_abort;
    n_launch = 0;
    addr(1'b0, ADR, 1'b0);
    n_valid = 0;
    i2crec_master_i.xfer(8'h3c, 1'b1, q, ack);
    recover();
    idle_chk();
    `CHK("launch", 0, n_launch)
    `CHK("valid", 1, n_valid)
    `CHK("wdata", 8'h3c, wr_data)
  endtask
  initial
  begin
    repeat (2) i2crec_master_i.tog();
    @(posedge mclk) #1 rst_b = 1'b1;
    repeat (8) @(posedge mclk);
    t_probe();
    t_read();
    t_recover();
    t_write();
    t_abort();
    end_of_test;
  end
endmodule // tb
